/* hdl/pdm_port_def_mux.sv */
// Pin-function multiplexer for ports D, E, F with port A wake-up, APB slave.
// Assumes pads resolve levels from OUT/OE_N; peripherals share CLK.
//
// Behaviour
// - PD0-3 code 10 gives touch 13-16
// - PD4-7 code 10 gives touch 17-20
// - PE3: capture unless PE2 captures, inverted std timer, touch 24
// - PE2: capture, std timer out, touch 23
// - PE1, PE0 code 10 give touch 22, 21
// - PE7: inverted compact timer, touch 26
// - PE6: compact timer out, touch 25
// - PE5: crystal terminal b, else ext clock
// - PE4 code 10 gives crystal terminal a
// - PF3: UART transmit, serial data line
// - PF2 code 10 gives I/O supply
// - PF1, PF0 code 10 give touch 28, 27
// - PF5, PF4: UART receive, serial clock
// - PF high select upper nibble reads zero
// - Data and direction registers reset all ones
// - New output pin drives high by default
// - Bit operations rewrite the whole byte
// - Enabled PA falling edge wakes sleeping device
//
// Added by the designer: the APB register port and the register offsets.
`include "pdm_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module pdm_port_def_mux import pdm_pkg::*; #(
   parameter int ADDR_W = 8
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [7:0] PA_IN,
   output logic [7:0] PA_OUT,
   output logic [7:0] PA_OE_N,
   input wire logic [7:0] PD_IN,
   output logic [7:0] PD_OUT,
   output logic [7:0] PD_OE_N,
   input wire logic [7:0] PE_IN,
   output logic [7:0] PE_OUT,
   output logic [7:0] PE_OE_N,
   input wire logic [5:0] PF_IN,
   output logic [5:0] PF_OUT,
   output logic [5:0] PF_OE_N,
   output logic [15:0] TOUCH_INPUT,
   output logic STANDARD_TIMER_CAPTURE_IN,
   input wire logic STANDARD_TIMER_OUT,
   input wire logic STANDARD_TIMER_OUT_INVERTED,
   input wire logic COMPACT_TIMER1_OUT,
   input wire logic COMPACT_TIMER1_OUT_INVERTED,
   output logic COMPACT_TIMER1_EXT_CLOCK,
   output logic CRYSTAL_TERMINAL_A_SEL,
   output logic CRYSTAL_TERMINAL_B_SEL,
   output logic IO_SUPPLY_PIN_SEL,
   input wire logic UART_TX,
   output logic UART_RX,
   input wire logic SERIAL_DATA_OUT,
   input wire logic SERIAL_DATA_OE_N,
   output logic SERIAL_DATA_INPUT_LINE,
   input wire logic SERIAL_CLOCK_OUT,
   input wire logic SERIAL_CLOCK_OE_N,
   output logic SERIAL_CLOCK_IN,
   input wire logic SLEEP_MODE,
   output logic WAKE_UP
);

   ////////////////////////////////////////////////////////////////////////
   // Pad input synchronisers

   logic [29:0] pad_raw;
   logic [29:0] sync1_r;
   logic [29:0] sync2_r;
   logic [29:0] sync3_r;
   logic [29:0] lvl_r;
   logic [7:0] pa_lvl;
   logic [7:0] pd_lvl;
   logic [7:0] pe_lvl;
   logic [5:0] pf_lvl;

   assign pad_raw = {PF_IN, PE_IN, PD_IN, PA_IN};

   genvar gi;
   generate
      for (gi = 0; gi < 30; gi++) begin : g_sync
         always_ff @(posedge CLK) begin
            if (!NRST) begin
               sync1_r[gi] <= 1'b1;
               sync2_r[gi] <= 1'b1;
               sync3_r[gi] <= 1'b1;
               lvl_r[gi] <= 1'b1;
            end else begin
               sync1_r[gi] <= pad_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
               sync3_r[gi] <= sync2_r[gi];
               // Level changes only once two stages agree
               if (sync2_r[gi] == sync3_r[gi]) begin
                  lvl_r[gi] <= sync3_r[gi];
               end
            end
         end
      end
   endgenerate

   assign pa_lvl = lvl_r[7:0];
   assign pd_lvl = lvl_r[15:8];
   assign pe_lvl = lvl_r[23:16];
   assign pf_lvl = lvl_r[29:24];

   ////////////////////////////////////////////////////////////////////////
   // APB handshake

   logic pready_r;
   logic acc_first;
   logic wr_commit;
   logic [7:0] addr8;
   logic addr_hi_ok;

   assign acc_first = PSEL & PENABLE & ~pready_r;
   assign wr_commit = PSEL & PENABLE & pready_r & PWRITE;
   assign addr8 = PADDR[7:0];
   assign addr_hi_ok = (PADDR >> 8) == '0;

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= acc_first;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   pdm_byte_t sel_d_lo_r;
   pdm_byte_t sel_d_hi_r;
   pdm_byte_t sel_e_lo_r;
   pdm_byte_t sel_e_hi_r;
   pdm_byte_t sel_f_lo_r;
   logic [3:0] sel_f_hi_r;
   pdm_byte_t pa_dat_r;
   pdm_byte_t pa_dir_r;
   pdm_byte_t pd_dat_r;
   pdm_byte_t pd_dir_r;
   pdm_byte_t pe_dat_r;
   pdm_byte_t pe_dir_r;
   logic [5:0] pf_dat_r;
   logic [5:0] pf_dir_r;
   pdm_byte_t wake_en_r;
   pdm_byte_t wdat;
   pdm_tgt_t bop_tgt;
   logic [2:0] bop_bit;
   logic bop_go;
   pdm_byte_t bop_src;
   pdm_byte_t bop_byte;

   assign wdat = PWDATA[7:0];
   assign bop_tgt = PWDATA[`PDM_BOP_TGT_LSB +: 3];
   assign bop_bit = PWDATA[`PDM_BOP_BIT_LSB +: 3];
   assign bop_go = wr_commit & addr_hi_ok & (addr8 == `PDM_OFF_BIT_OP);

   // Reads the whole port, replaces one bit, writes the byte back
   always_comb begin
      case (bop_tgt)
         3'h0: bop_src = pa_lvl;
         3'h1: bop_src = pa_dir_r;
         3'h2: bop_src = pd_lvl;
         3'h3: bop_src = pd_dir_r;
         3'h4: bop_src = pe_lvl;
         3'h5: bop_src = pe_dir_r;
         3'h6: bop_src = {2'h0, pf_lvl};
         default: bop_src = {2'h0, pf_dir_r};
      endcase
      bop_byte = bop_src;
      bop_byte[bop_bit] = PWDATA[`PDM_BOP_VAL_BIT];
   end

   function automatic logic hit(input logic [7:0] off);
      hit = wr_commit & addr_hi_ok & (addr8 == off);
   endfunction : hit

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         sel_d_lo_r <= `PDM_SEL_RST;
         sel_d_hi_r <= `PDM_SEL_RST;
         sel_e_lo_r <= `PDM_SEL_RST;
         sel_e_hi_r <= `PDM_SEL_RST;
         sel_f_lo_r <= `PDM_SEL_RST;
         sel_f_hi_r <= `PDM_SEL_F_HI_RST;
      end else begin
         if (hit(`PDM_OFF_SEL_D_LO)) sel_d_lo_r <= wdat;
         if (hit(`PDM_OFF_SEL_D_HI)) sel_d_hi_r <= wdat;
         if (hit(`PDM_OFF_SEL_E_LO)) sel_e_lo_r <= wdat;
         if (hit(`PDM_OFF_SEL_E_HI)) sel_e_hi_r <= wdat;
         if (hit(`PDM_OFF_SEL_F_LO)) sel_f_lo_r <= wdat;
         if (hit(`PDM_OFF_SEL_F_HI)) sel_f_hi_r <= wdat[3:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         pa_dat_r <= `PDM_PORT_RST;
         pa_dir_r <= `PDM_PORT_RST;
         pd_dat_r <= `PDM_PORT_RST;
         pd_dir_r <= `PDM_PORT_RST;
         pe_dat_r <= `PDM_PORT_RST;
         pe_dir_r <= `PDM_PORT_RST;
         pf_dat_r <= `PDM_PF_RST;
         pf_dir_r <= `PDM_PF_RST;
         wake_en_r <= `PDM_WAKE_RST;
      end else begin
         if (hit(`PDM_OFF_PA_DATA) | (bop_go & (bop_tgt == 3'h0))) pa_dat_r <= bop_go ? bop_byte : wdat;
         if (hit(`PDM_OFF_PA_DIR) | (bop_go & (bop_tgt == 3'h1))) pa_dir_r <= bop_go ? bop_byte : wdat;
         if (hit(`PDM_OFF_PD_DATA) | (bop_go & (bop_tgt == 3'h2))) pd_dat_r <= bop_go ? bop_byte : wdat;
         if (hit(`PDM_OFF_PD_DIR) | (bop_go & (bop_tgt == 3'h3))) pd_dir_r <= bop_go ? bop_byte : wdat;
         if (hit(`PDM_OFF_PE_DATA) | (bop_go & (bop_tgt == 3'h4))) pe_dat_r <= bop_go ? bop_byte : wdat;
         if (hit(`PDM_OFF_PE_DIR) | (bop_go & (bop_tgt == 3'h5))) pe_dir_r <= bop_go ? bop_byte : wdat;
         if (hit(`PDM_OFF_PF_DATA) | (bop_go & (bop_tgt == 3'h6))) pf_dat_r <= bop_go ? bop_byte[5:0] : wdat[5:0];
         if (hit(`PDM_OFF_PF_DIR) | (bop_go & (bop_tgt == 3'h7))) pf_dir_r <= bop_go ? bop_byte[5:0] : wdat[5:0];
         if (hit(`PDM_OFF_PA_WAKE)) wake_en_r <= wdat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read decode

   pdm_byte_t rd_byte;
   logic rd_ok;

   always_comb begin
      rd_ok = addr_hi_ok;
      case (addr8)
         `PDM_OFF_SEL_D_LO: rd_byte = sel_d_lo_r;
         `PDM_OFF_SEL_D_HI: rd_byte = sel_d_hi_r;
         `PDM_OFF_SEL_E_LO: rd_byte = sel_e_lo_r;
         `PDM_OFF_SEL_E_HI: rd_byte = sel_e_hi_r;
         `PDM_OFF_SEL_F_LO: rd_byte = sel_f_lo_r;
         `PDM_OFF_SEL_F_HI: rd_byte = {4'h0, sel_f_hi_r};
         `PDM_OFF_PA_DATA: rd_byte = pa_lvl;
         `PDM_OFF_PA_DIR: rd_byte = pa_dir_r;
         `PDM_OFF_PD_DATA: rd_byte = pd_lvl;
         `PDM_OFF_PD_DIR: rd_byte = pd_dir_r;
         `PDM_OFF_PE_DATA: rd_byte = pe_lvl;
         `PDM_OFF_PE_DIR: rd_byte = pe_dir_r;
         `PDM_OFF_PF_DATA: rd_byte = {2'h0, pf_lvl};
         `PDM_OFF_PF_DIR: rd_byte = {2'h0, pf_dir_r};
         `PDM_OFF_PA_WAKE: rd_byte = wake_en_r;
         `PDM_OFF_BIT_OP: rd_byte = 8'h00;
         default: begin
            rd_byte = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
      if (!rd_ok) rd_byte = 8'h00;
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (acc_first) begin
         PRDATA <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         PSLVERR <= ~rd_ok;
      end else begin
         PSLVERR <= 1'b0;
      end
   end

   assign PREADY = pready_r;

   ////////////////////////////////////////////////////////////////////////
   // Function multiplexer

   logic [15:0] sel_d;
   logic [15:0] sel_e;
   logic [11:0] sel_f;
   logic [29:0] out_nxt;
   logic [29:0] oe_n_nxt;
   logic [15:0] touch_nxt;
   logic cap_nxt;
   logic ctck_nxt;
   logic xa_nxt;
   logic xb_nxt;
   logic vio_nxt;
   logic rx_nxt;
   logic sda_nxt;
   logic scl_nxt;

   assign sel_d = {sel_d_hi_r, sel_d_lo_r};
   assign sel_e = {sel_e_hi_r, sel_e_lo_r};
   assign sel_f = {sel_f_hi_r, sel_f_lo_r};

   always_comb begin
      // General I/O: latch drives when direction bit is low
      out_nxt = {pf_dat_r, pe_dat_r, pd_dat_r, pa_dat_r};
      oe_n_nxt = {pf_dir_r, pe_dir_r, pd_dir_r, pa_dir_r};
      touch_nxt = 16'h0000;
      cap_nxt = 1'b0;
      ctck_nxt = 1'b0;
      xa_nxt = 1'b0;
      xb_nxt = 1'b0;
      vio_nxt = 1'b0;
      rx_nxt = 1'b1;
      sda_nxt = 1'b1;
      scl_nxt = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (sel_d[2*i +: 2] == `PDM_FS_ALT2) begin
            touch_nxt[i] = pd_lvl[i];
            oe_n_nxt[8+i] = 1'b1;
         end
      end
      for (int i = 0; i < 2; i++) begin
         if (sel_e[2*i +: 2] == `PDM_FS_ALT2) begin
            touch_nxt[8+i] = pe_lvl[i];
            oe_n_nxt[16+i] = 1'b1;
         end
      end
      case (sel_e[7:6])
         `PDM_FS_ALT1: begin
            out_nxt[19] = STANDARD_TIMER_OUT_INVERTED;
            oe_n_nxt[19] = 1'b0;
         end
         `PDM_FS_ALT2: begin
            touch_nxt[11] = pe_lvl[3];
            oe_n_nxt[19] = 1'b1;
         end
         default: cap_nxt = pe_lvl[3];
      endcase
      case (sel_e[5:4])
         `PDM_FS_ALT1: begin
            out_nxt[18] = STANDARD_TIMER_OUT;
            oe_n_nxt[18] = 1'b0;
         end
         `PDM_FS_ALT2: begin
            touch_nxt[10] = pe_lvl[2];
            oe_n_nxt[18] = 1'b1;
         end
         default: cap_nxt = pe_lvl[2];
      endcase
      if (sel_e[9:8] == `PDM_FS_ALT2) begin
         xa_nxt = 1'b1;
         oe_n_nxt[20] = 1'b1;
      end
      if (sel_e[11:10] == `PDM_FS_ALT2) begin
         xb_nxt = 1'b1;
         oe_n_nxt[21] = 1'b1;
      end else begin
         ctck_nxt = pe_lvl[5];
      end
      case (sel_e[13:12])
         `PDM_FS_ALT1: begin
            out_nxt[22] = COMPACT_TIMER1_OUT;
            oe_n_nxt[22] = 1'b0;
         end
         `PDM_FS_ALT2: begin
            touch_nxt[12] = pe_lvl[6];
            oe_n_nxt[22] = 1'b1;
         end
         default: ;
      endcase
      case (sel_e[15:14])
         `PDM_FS_ALT1: begin
            out_nxt[23] = COMPACT_TIMER1_OUT_INVERTED;
            oe_n_nxt[23] = 1'b0;
         end
         `PDM_FS_ALT2: begin
            touch_nxt[13] = pe_lvl[7];
            oe_n_nxt[23] = 1'b1;
         end
         default: ;
      endcase
      for (int i = 0; i < 2; i++) begin
         if (sel_f[2*i +: 2] == `PDM_FS_ALT2) begin
            touch_nxt[14+i] = pf_lvl[i];
            oe_n_nxt[24+i] = 1'b1;
         end
      end
      if (sel_f[5:4] == `PDM_FS_ALT2) begin
         vio_nxt = 1'b1;
         oe_n_nxt[26] = 1'b1;
      end
      case (sel_f[7:6])
         `PDM_FS_ALT1: begin
            out_nxt[27] = UART_TX;
            oe_n_nxt[27] = 1'b0;
         end
         `PDM_FS_ALT2: begin
            out_nxt[27] = SERIAL_DATA_OUT;
            oe_n_nxt[27] = SERIAL_DATA_OE_N;
            sda_nxt = pf_lvl[3];
         end
         default: ;
      endcase
      // PF4 takes precedence over PF5 when both claim the same input
      for (int i = 5; i >= 4; i--) begin
         case (sel_f[2*i +: 2])
            `PDM_FS_ALT1: begin
               rx_nxt = pf_lvl[i];
               oe_n_nxt[24+i] = 1'b1;
            end
            `PDM_FS_ALT2: begin
               out_nxt[24+i] = SERIAL_CLOCK_OUT;
               oe_n_nxt[24+i] = SERIAL_CLOCK_OE_N;
               scl_nxt = pf_lvl[i];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         {PF_OUT, PE_OUT, PD_OUT, PA_OUT} <= {2'h3, 24'hff_ffff, 4'hf};
         {PF_OE_N, PE_OE_N, PD_OE_N, PA_OE_N} <= {2'h3, 24'hff_ffff, 4'hf};
         TOUCH_INPUT <= 16'h0000;
         STANDARD_TIMER_CAPTURE_IN <= 1'b0;
         COMPACT_TIMER1_EXT_CLOCK <= 1'b0;
         CRYSTAL_TERMINAL_A_SEL <= 1'b0;
         CRYSTAL_TERMINAL_B_SEL <= 1'b0;
         IO_SUPPLY_PIN_SEL <= 1'b0;
         UART_RX <= 1'b1;
         SERIAL_DATA_INPUT_LINE <= 1'b1;
         SERIAL_CLOCK_IN <= 1'b1;
      end else begin
         {PF_OUT, PE_OUT, PD_OUT, PA_OUT} <= out_nxt;
         {PF_OE_N, PE_OE_N, PD_OE_N, PA_OE_N} <= oe_n_nxt;
         TOUCH_INPUT <= touch_nxt;
         STANDARD_TIMER_CAPTURE_IN <= cap_nxt;
         COMPACT_TIMER1_EXT_CLOCK <= ctck_nxt;
         CRYSTAL_TERMINAL_A_SEL <= xa_nxt;
         CRYSTAL_TERMINAL_B_SEL <= xb_nxt;
         IO_SUPPLY_PIN_SEL <= vio_nxt;
         UART_RX <= rx_nxt;
         SERIAL_DATA_INPUT_LINE <= sda_nxt;
         SERIAL_CLOCK_IN <= scl_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port A wake-up

   pdm_byte_t pa_prev_r;
   pdm_byte_t pa_fall;

   assign pa_fall = pa_prev_r & ~pa_lvl & wake_en_r;

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         pa_prev_r <= `PDM_PORT_RST;
         WAKE_UP <= 1'b0;
      end else begin
         pa_prev_r <= pa_lvl;
         WAKE_UP <= SLEEP_MODE & (|pa_fall);
      end
   end

endmodule : pdm_port_def_mux

`default_nettype wire

/* hdl/pdm_consts.svh */
// Constants for the port D/E/F pin-function multiplexer.
// Assumes an APB slave with 8-bit register words in the low data bits.
`ifndef PDM_CONSTS_SVH
`define PDM_CONSTS_SVH

// Register byte offsets
`define PDM_OFF_SEL_D_LO 8'h00
`define PDM_OFF_SEL_D_HI 8'h04
`define PDM_OFF_SEL_E_LO 8'h08
`define PDM_OFF_SEL_E_HI 8'h0c
`define PDM_OFF_SEL_F_LO 8'h10
`define PDM_OFF_SEL_F_HI 8'h14
`define PDM_OFF_PA_DATA 8'h20
`define PDM_OFF_PA_DIR 8'h24
`define PDM_OFF_PD_DATA 8'h28
`define PDM_OFF_PD_DIR 8'h2c
`define PDM_OFF_PE_DATA 8'h30
`define PDM_OFF_PE_DIR 8'h34
`define PDM_OFF_PF_DATA 8'h38
`define PDM_OFF_PF_DIR 8'h3c
`define PDM_OFF_PA_WAKE 8'h40
`define PDM_OFF_BIT_OP 8'h44

// Bit operation word fields
`define PDM_BOP_BIT_LSB 0
`define PDM_BOP_TGT_LSB 4
`define PDM_BOP_VAL_BIT 8

// Selection codes
`define PDM_FS_ALT1 2'h1
`define PDM_FS_ALT2 2'h2

// Reset values
`define PDM_SEL_RST 8'h00
`define PDM_SEL_F_HI_RST 4'h0
`define PDM_PORT_RST 8'hff
`define PDM_PF_RST 6'h3f
`define PDM_WAKE_RST 8'h00

`endif

/* hdl/pdm_pkg.sv */
// Types for the port D/E/F pin-function multiplexer.
// Assumes nothing beyond the constants header.
package pdm_pkg;
   typedef logic [7:0] pdm_byte_t;
   typedef logic [1:0] pdm_fsel_t;
   typedef logic [2:0] pdm_tgt_t;
endpackage : pdm_pkg

/* testbench/pdm_pad_model.sv */
// Pad model for ports A, D, E and F of the pin-function multiplexer.
// Assumes the board side always drives a level wherever the design releases a pin.
`timescale 1ns/10ps
`default_nettype none

module pdm_pad_model #(
   parameter int W = 8
) (
   input wire logic [W-1:0] drv,
   input wire logic [W-1:0] oe_n,
   input wire logic [W-1:0] ext,
   output logic [W-1:0] lvl
);
   // Design wins where it drives; elsewhere the board level shows
   assign lvl = (drv & ~oe_n) | (ext & oe_n);
endmodule : pdm_pad_model

`default_nettype wire

/* testbench/pdm_port_def_mux_monitor.sv */
// Checker for the pin-function multiplexer, bound to its top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module pdm_monitor #(
   parameter int ADDR_W = 8
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [7:0] PD_OUT,
   input wire logic [7:0] PD_OE_N,
   input wire logic [7:0] PE_OE_N,
   input wire logic [5:0] PF_OE_N,
   input wire logic [15:0] TOUCH_INPUT,
   input wire logic COMPACT_TIMER1_EXT_CLOCK,
   input wire logic CRYSTAL_TERMINAL_A_SEL,
   input wire logic CRYSTAL_TERMINAL_B_SEL,
   input wire logic IO_SUPPLY_PIN_SEL,
   input wire logic SLEEP_MODE,
   input wire logic WAKE_UP
);
   default clocking mon_cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   a_rdy_after_access: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("ready missing after access");
   a_rdy_single_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   a_unmapped_error: assert property (PREADY && PADDR > 8'h44 |-> PSLVERR)
      else $error("unmapped access without error");
   a_fsel_hi_zero: assert property (PREADY && !PWRITE && PADDR == 8'h14 |-> PRDATA[31:4] == 28'h0)
      else $error("upper select bits read nonzero");
   a_reset_defaults: assert property ($rose(NRST) |-> PD_OUT == 8'hff && PD_OE_N == 8'hff && TOUCH_INPUT == 16'h0)
      else $error("pad state wrong after reset");
   a_touch_releases: assert property (TOUCH_INPUT[0] |-> PD_OE_N[0])
      else $error("touch pin still driven");
   a_crystal_a_free: assert property (CRYSTAL_TERMINAL_A_SEL |-> PE_OE_N[4])
      else $error("crystal pin still driven");
   a_ext_clk_gate: assert property (CRYSTAL_TERMINAL_B_SEL |-> PE_OE_N[5] && !COMPACT_TIMER1_EXT_CLOCK)
      else $error("crystal pin feeds timer clock");
   a_supply_free: assert property (IO_SUPPLY_PIN_SEL |-> PF_OE_N[2])
      else $error("supply pin still driven");
   a_wake_needs_sleep: assert property (!SLEEP_MODE && !$past(SLEEP_MODE) && !$past(SLEEP_MODE, 2) |-> !WAKE_UP)
      else $error("wake while awake");
   a_wake_pulse: assert property (WAKE_UP |=> !WAKE_UP)
      else $error("wake longer than one cycle");
endmodule : pdm_monitor

bind pdm_port_def_mux pdm_monitor #(.ADDR_W(ADDR_W)) u_mon (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .PD_OUT(PD_OUT), .PD_OE_N(PD_OE_N), .PE_OE_N(PE_OE_N), .PF_OE_N(PF_OE_N), .TOUCH_INPUT(TOUCH_INPUT),
   .COMPACT_TIMER1_EXT_CLOCK(COMPACT_TIMER1_EXT_CLOCK), .CRYSTAL_TERMINAL_A_SEL(CRYSTAL_TERMINAL_A_SEL),
   .CRYSTAL_TERMINAL_B_SEL(CRYSTAL_TERMINAL_B_SEL), .IO_SUPPLY_PIN_SEL(IO_SUPPLY_PIN_SEL),
   .SLEEP_MODE(SLEEP_MODE), .WAKE_UP(WAKE_UP));

`default_nettype wire

/* testbench/port_def_function_select_mux_bench.sv */
// Self-checking bench for the pin-function multiplexer over APB.
// Assumes the constants header and pad models for every port.
`include "pdm_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module port_def_function_select_mux_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, cap, ext_clk, xa, xb, sup, urx, sdi, sci, wake;
   logic [7:0] pa_out, pa_oe_n, pa_lvl, pd_out, pd_oe_n, pd_lvl, pe_out, pe_oe_n, pe_lvl;
   logic [5:0] pf_out, pf_oe_n, pf_lvl;
   logic [15:0] touch;
   logic [7:0] pa_ext = 8'hff;
   logic [7:0] pd_ext = 8'hff;
   logic [7:0] pe_ext = 8'hff;
   logic [5:0] pf_ext = 6'h3f;
   logic st_o = 1'b0;
   logic st_ob = 1'b0;
   logic ct_o = 1'b0;
   logic ct_ob = 1'b0;
   logic utx = 1'b1;
   logic sleep = 1'b0;
   logic sdo = 1'b0;
   logic sdo_oe_n = 1'b1;
   logic sco = 1'b0;
   logic sco_oe_n = 1'b1;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;

   always #10 clk = ~clk;

   pdm_pad_model #(.W(8)) pa_pad (.drv(pa_out), .oe_n(pa_oe_n), .ext(pa_ext), .lvl(pa_lvl));
   pdm_pad_model #(.W(8)) pd_pad (.drv(pd_out), .oe_n(pd_oe_n), .ext(pd_ext), .lvl(pd_lvl));
   pdm_pad_model #(.W(8)) pe_pad (.drv(pe_out), .oe_n(pe_oe_n), .ext(pe_ext), .lvl(pe_lvl));
   pdm_pad_model #(.W(6)) pf_pad (.drv(pf_out), .oe_n(pf_oe_n), .ext(pf_ext), .lvl(pf_lvl));

   pdm_port_def_mux #(.ADDR_W(8)) uut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PA_IN(pa_lvl), .PA_OUT(pa_out), .PA_OE_N(pa_oe_n), .PD_IN(pd_lvl), .PD_OUT(pd_out), .PD_OE_N(pd_oe_n),
      .PE_IN(pe_lvl), .PE_OUT(pe_out), .PE_OE_N(pe_oe_n), .PF_IN(pf_lvl), .PF_OUT(pf_out), .PF_OE_N(pf_oe_n),
      .TOUCH_INPUT(touch), .STANDARD_TIMER_CAPTURE_IN(cap), .STANDARD_TIMER_OUT(st_o),
      .STANDARD_TIMER_OUT_INVERTED(st_ob), .COMPACT_TIMER1_OUT(ct_o), .COMPACT_TIMER1_OUT_INVERTED(ct_ob),
      .COMPACT_TIMER1_EXT_CLOCK(ext_clk), .CRYSTAL_TERMINAL_A_SEL(xa), .CRYSTAL_TERMINAL_B_SEL(xb),
      .IO_SUPPLY_PIN_SEL(sup), .UART_TX(utx), .UART_RX(urx), .SERIAL_DATA_OUT(sdo),
      .SERIAL_DATA_OE_N(sdo_oe_n), .SERIAL_DATA_INPUT_LINE(sdi), .SERIAL_CLOCK_OUT(sco),
      .SERIAL_CLOCK_OE_N(sco_oe_n), .SERIAL_CLOCK_IN(sci), .SLEEP_MODE(sleep), .WAKE_UP(wake));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(a, 1'b1, d, q, e);
      check("write error", e, 32'h0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(a, 1'b0, 32'h0, q, e);
      check("read data", q, exp);
      check("read error", e, 32'h0);
   endtask : rd

   // Pad levels pass a synchroniser before they reach the outputs
   task automatic settle;
      repeat (8) @(posedge clk);
   endtask : settle

   task automatic wake_count(input logic [7:0] v, input logic s, input int exp);
      int hits;
      hits = 0;
      sleep <= s;
      pa_ext <= 8'hff;
      settle();
      pa_ext <= v;
      repeat (20) begin
         @(posedge clk);
         if (wake === 1'b1) hits++;
      end
      check("wake pulses", hits, exp);
   endtask : wake_count

   task automatic end_sim;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] q;
      logic e;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
      for (int i = 0; i < 3; i++) rd(8'(36 + 8 * i), 32'hff);
      rd(`PDM_OFF_PF_DIR, 32'h3f);
      rd(`PDM_OFF_PD_DATA, 32'hff);
      wr(`PDM_OFF_SEL_F_HI, 32'hff);
      rd(`PDM_OFF_SEL_F_HI, 32'h0f);
      // Code 10 on every pin but PF4, PF5: touch, crystal, supply and serial data
      pd_ext <= 8'h5b;
      pe_ext <= 8'hc3;
      pf_ext <= 6'h2d;
      for (int i = 0; i < 5; i++) wr(8'(4 * i), 32'haa);
      settle();
      check("touch", touch, {pf_ext[1:0], pe_ext[7:6], pe_ext[3:0], pd_ext});
      check("crystal a", xa, 32'h1);
      check("crystal b", xb | ext_clk << 1, 32'h1);
      check("supply", sup, 32'h1);
      check("serial data", sdi, pf_ext[3]);
      sdo_oe_n <= 1'b0;
      settle();
      check("serial data drive", {pf_oe_n[3], pf_out[3]}, {1'b0, sdo});
      check("capture", cap, 32'h0);
      // Code 01: timer and transmit outputs take the pads
      wr(`PDM_OFF_SEL_E_LO, 32'h50);
      wr(`PDM_OFF_SEL_E_HI, 32'h50);
      wr(`PDM_OFF_SEL_F_LO, 32'h40);
      wr(`PDM_OFF_SEL_F_HI, 32'h01);
      for (int k = 0; k < 2; k++) begin
         st_o <= ~k[0];
         st_ob <= k[0];
         ct_o <= k[0];
         ct_ob <= ~k[0];
         utx <= k[0];
         settle();
         check("timer pads", pe_out & 8'hcc, {ct_ob, ct_o, 2'b00, st_ob, st_o, 2'b00});
         check("timer drive", pe_oe_n & 8'hcc, 32'h0);
         check("transmit", {pf_oe_n[3], pf_out[3]}, {1'b0, utx});
      end
      check("receive", urx, pf_ext[4]);
      check("ext clock", ext_clk, pe_ext[5]);
      // Code 10 on both upper F pins and code 11 on capture pins
      pe_ext <= 8'hc7;
      wr(`PDM_OFF_SEL_F_HI, 32'h0a);
      wr(`PDM_OFF_SEL_E_LO, 32'hf0);
      settle();
      check("serial clock", sci, pf_ext[4]);
      sco_oe_n <= 1'b0;
      settle();
      check("serial clock drive", {pf_oe_n[5:4], pf_out[5:4]}, {2'b00, sco, sco});
      check("capture", cap, pe_ext[2]);
      // Output without data write drives high, then bit operations
      wr(`PDM_OFF_SEL_D_LO, 32'h0);
      wr(`PDM_OFF_SEL_D_HI, 32'h0);
      wr(`PDM_OFF_PD_DIR, 32'hfe);
      settle();
      check("pd drive", {pd_oe_n, pd_out}, 16'hfeff);
      wr(`PDM_OFF_BIT_OP, 32'h034);
      rd(`PDM_OFF_PD_DIR, 32'hee);
      settle();
      wr(`PDM_OFF_BIT_OP, 32'h021);
      settle();
      check("pd rewrite", pd_out, (pd_ext | ~8'hee) & 8'hfd);
      apb(8'h48, 1'b1, 32'hff, q, e);
      check("unmapped write", e, 32'h1);
      apb(8'h50, 1'b0, 32'h0, q, e);
      check("unmapped read", {q, e}, 33'h1);
      rd(`PDM_OFF_BIT_OP, 32'h0);
      wr(`PDM_OFF_PA_WAKE, 32'h01);
      wake_count(8'hfe, 1'b1, 1);
      wake_count(8'hfd, 1'b1, 0);
      wake_count(8'hfe, 1'b0, 0);
      end_sim();
   end
endmodule : port_def_function_select_mux_bench

`default_nettype wire
